//--- design/ars_defines.svh
// Constants of the arithmetic right-shift unit.
// Assumes inclusion by bare name from design files and packages.
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH

// Data widths
`define ARS_WORD_W        16
`define ARS_ACC_W         36
`define ARS_AMT_W         4
// Flag positions in the condition flags byte
`define ARS_FLG_C         0
`define ARS_FLG_V         1
`define ARS_FLG_Z         2
`define ARS_FLG_N         3
`define ARS_FLG_U         4
`define ARS_FLG_E         5
`define ARS_FLG_L         6
`define ARS_FLG_SZ        7
// Timing: oscillator cycles per operation before result is valid
`define ARS_BASE_CYCLES   2
// Reset values
`define ARS_FLAGS_RST     8'h00
`define ARS_ACC_RST       36'h0_0000_0000

`endif

//--- design/ars_pkg.sv
// Types of the arithmetic right-shift unit.
// Assumes ars_defines.svh is reachable on the include path.
`include "ars_defines.svh"
package ars_pkg;

   // Operation selects
   typedef enum logic [1:0] {
      ARS_OP_SINGLE = 2'b00,
      ARS_OP_ACCUM  = 2'b01,
      ARS_OP_MULTI  = 2'b10,
      ARS_OP_NONE   = 2'b11
   } ars_op_t;

   // Source pair selects for multi-bit operations
   typedef enum logic [2:0] {
      ARS_PR_Y1_X0 = 3'b000,
      ARS_PR_Y0_X0 = 3'b001,
      ARS_PR_Y1_Y0 = 3'b010,
      ARS_PR_Y0_Y0 = 3'b011,
      ARS_PR_A1_Y0 = 3'b100,
      ARS_PR_B1_Y1 = 3'b101,
      ARS_PR_BAD6  = 3'b110,
      ARS_PR_BAD7  = 3'b111
   } ars_pair_t;

   // Destination kind: accumulator or 16-bit register
   typedef enum logic [1:0] {
      ARS_DST_ACC_A = 2'b00,
      ARS_DST_ACC_B = 2'b01,
      ARS_DST_REG16 = 2'b10,
      ARS_DST_BAD   = 2'b11
   } ars_dst_t;

   // Register operands from the register file
   typedef struct packed {
      logic [15:0] x0;
      logic [15:0] y0;
      logic [15:0] y1;
      logic [35:0] acc_a;
      logic [35:0] acc_b;
      logic [15:0] reg16;
   } ars_regs_t;

   // Issued operation from the decoder
   typedef struct packed {
      ars_op_t   op;
      ars_pair_t pair;
      ars_dst_t  dst;
      logic [1:0] mv_extra;
      logic       mv_limited;
      logic       mv_size_growth;
      logic       mv_read_active;
   } ars_cmd_t;

   // Result handed back to the register file
   typedef struct packed {
      ars_dst_t    dst;
      logic [35:0] value;
      logic [7:0]  flags;
   } ars_result_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ARS_ST_IDLE = 2'b00,
      ARS_ST_EXEC = 2'b01,
      ARS_ST_MOVE = 2'b10,
      ARS_ST_DONE = 2'b11
   } ars_state_t;

endpackage

//--- design/ars_barrel.sv
// Arithmetic barrel shifter, right by a small amount.
// Assumes a combinational use; no clock inside.
`timescale 1ns/10ps
module ars_barrel
   import ars_pkg::*;
#(
   parameter int WIDTH = 36,
   parameter int AMT_W = 4
) (
   // Operand and amount
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic [AMT_W-1:0] amt_i,
   // Shifted value
   output logic      [WIDTH-1:0] data_o
);

   // One stage per amount bit, sign fill from the top
   logic [WIDTH-1:0] stage [0:AMT_W];
   assign stage[0] = data_i;

   genvar g;
   generate
      for (g = 0; g < AMT_W; g++) begin : g_stage
         assign stage[g+1] = amt_i[g] ? WIDTH'($signed(stage[g]) >>> (2**g)) : stage[g];
      end
   endgenerate

   assign data_o = stage[AMT_W];

endmodule // ars_barrel

//--- design/ars_flags.sv
// Condition flag builder for shift results.
// Assumes result values and move status arrive from the same clock.
`timescale 1ns/10ps
`include "ars_defines.svh"
module ars_flags
   import ars_pkg::*;
(
   // Result and context
   input  wire logic [35:0] value_i,
   input  wire logic        is_acc_i,
   input  wire ars_op_t     op_i,
   input  wire logic        carry_i,
   input  wire logic        mv_limited_i,
   input  wire logic        mv_size_growth_i,
   input  wire logic [7:0]  flags_prev_i,
   // New flags
   output logic      [7:0]  flags_o
);

   // Sign, zero and top bits of the result
   wire       msb16     = value_i[15];
   wire       msb36     = value_i[35];
   wire       zero_acc  = (value_i == 36'h0_0000_0000);
   wire       zero_16   = (value_i[15:0] == 16'h0000);
   wire       neg       = is_acc_i ? msb36 : msb16;
   wire       zero      = is_acc_i ? zero_acc : zero_16;
   // Extension in use: bits 35..31 not all equal
   wire       ext_use   = is_acc_i && !((&value_i[35:31]) || !(|value_i[35:31]));
   // Unnormalized: bits 31 and 30 agree and extension idle; for a 16-bit result, bits 15 and 14 agree
   wire       unnorm    = is_acc_i ? (!ext_use && (value_i[31] == value_i[30]))
                                   : (value_i[15] == value_i[14]);
   wire       is_single = (op_i == ARS_OP_SINGLE);

   // Merge per operation; others keep their old value
   always_comb begin
      flags_o = flags_prev_i;
      flags_o[`ARS_FLG_N] = neg;
      flags_o[`ARS_FLG_Z] = zero;
      if (is_single) begin
         flags_o[`ARS_FLG_C]  = carry_i;
         flags_o[`ARS_FLG_V]  = 1'b0;
         flags_o[`ARS_FLG_E]  = ext_use;
         flags_o[`ARS_FLG_U]  = unnorm;
         flags_o[`ARS_FLG_L]  = mv_limited_i;
         flags_o[`ARS_FLG_SZ] = mv_size_growth_i;
      end
   end

endmodule // ars_flags

//--- design/ars_unit.sv
// Arithmetic right-shift slice: single-bit, accumulate and multi-bit forms.
// Assumes the decoder issues one command at a time and waits for done.
`timescale 1ns/10ps
`include "ars_defines.svh"
module ars_unit
   import ars_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   // Command from decoder
   input  wire logic        cmd_valid_i,
   input  wire ars_cmd_t    cmd_i,
   input  wire ars_regs_t   regs_i,
   input  wire logic [7:0]  flags_i,
   input  wire logic        limit_enable_bit_i,
   // Handshake and result
   output logic             cmd_ready_o,
   output logic             result_valid_o,
   output ars_result_t      result_o,
   output logic             illegal_o
);

   // Sequencer state and move-cycle count
   ars_state_t  state;
   ars_state_t  next_state;
   logic [1:0]  mv_cnt;
   logic [1:0]  next_mv_cnt;

   // Command, operands and flags captured at the taking edge
   ars_cmd_t    cmd;
   ars_regs_t   regs;
   logic [7:0]  flags_prev;

   // Registered result toward the register file
   ars_result_t result;
   logic        result_valid;
   logic        illegal;

   // Source pair decode
   logic [15:0] src1;
   logic [15:0] src2;
   logic        pair_ok;
   always_comb begin
      src1    = 16'h0000;
      src2    = 16'h0000;
      pair_ok = 1'b1;
      case (cmd.pair)
         ARS_PR_Y1_X0: begin
            src1 = regs.y1;
            src2 = regs.x0;
         end
         ARS_PR_Y0_X0: begin
            src1 = regs.y0;
            src2 = regs.x0;
         end
         ARS_PR_Y1_Y0: begin
            src1 = regs.y1;
            src2 = regs.y0;
         end
         ARS_PR_Y0_Y0: begin
            src1 = regs.y0;
            src2 = regs.y0;
         end
         ARS_PR_A1_Y0: begin
            src1 = regs.acc_a[31:16];                                // Upper word of A
            src2 = regs.y0;
         end
         ARS_PR_B1_Y1: begin
            src1 = regs.acc_b[31:16];                                // Upper word of B
            src2 = regs.y1;
         end
         default: begin
            pair_ok = 1'b0;
         end
      endcase
   end

   // Destination decode
   wire         dst_is_acc = (cmd.dst == ARS_DST_ACC_A) || (cmd.dst == ARS_DST_ACC_B);
   wire         dst_ok     = (cmd.dst != ARS_DST_BAD);
   wire         dst_is_b   = (cmd.dst == ARS_DST_ACC_B);
   wire  [35:0] dst_acc    = dst_is_b ? regs.acc_b : regs.acc_a;
   wire  [35:0] dst_val    = dst_is_acc ? dst_acc : {20'h0_0000, regs.reg16};

   // Legality of pair and destination per operation
   wire         single_ok  = dst_ok;
   wire         accum_ok   = pair_ok && dst_is_acc;
   wire         multi_ok   = pair_ok && dst_ok;

   // Single-bit shift, top bit held
   wire  [35:0] single_acc = {dst_val[35], dst_val[35:1]};
   wire  [15:0] single_16  = {dst_val[15], dst_val[15:1]};
   wire  [35:0] single_res = dst_is_acc ? single_acc : {20'h0_0000, single_16};
   wire         single_c   = dst_val[0];

   // Shift amount: four low bits of the second source
   wire  [`ARS_AMT_W-1:0] amt = src2[`ARS_AMT_W-1:0];

   // Accumulate: sign-extend, append zeros, shift, add
   wire  [3:0]  acc_ext    = {4{src1[15]}};
   wire  [35:0] acc_wide   = {acc_ext, src1, 16'h0000};
   logic [35:0] acc_shift;
   ars_barrel #(
      .WIDTH (`ARS_ACC_W),
      .AMT_W (`ARS_AMT_W)
   ) u_acc_shift (
      .data_i (acc_wide),
      .amt_i  (amt),
      .data_o (acc_shift)
   );

   // Add into the destination accumulator, never limited
   wire  [35:0] accum_res  = 36'(acc_shift + dst_acc);

   // Multi-bit shift of the 16-bit source
   logic [15:0] multi_16;
   ars_barrel #(
      .WIDTH (`ARS_WORD_W),
      .AMT_W (`ARS_AMT_W)
   ) u_multi_shift (
      .data_i (src1),
      .amt_i  (amt),
      .data_o (multi_16)
   );

   // Accumulator target: upper word shifted, lower cleared, extended from 31
   wire  [35:0] multi_acc  = {{4{multi_16[15]}}, multi_16, 16'h0000};
   wire  [35:0] multi_reg  = {20'h0_0000, multi_16};
   wire  [35:0] multi_res  = dst_is_acc ? multi_acc : multi_reg;

   // Result and legality select
   logic [35:0] op_res;
   logic        op_ok;
   always_comb begin
      op_res = 36'h0_0000_0000;
      op_ok  = 1'b0;
      case (cmd.op)
         ARS_OP_SINGLE: begin
            op_res = single_res;
            op_ok  = single_ok;
         end
         ARS_OP_ACCUM: begin
            op_res = accum_res;
            op_ok  = accum_ok;
         end
         ARS_OP_MULTI: begin
            op_res = multi_res;
            op_ok  = multi_ok;
         end
         default: begin
            op_res = 36'h0_0000_0000;
            op_ok  = 1'b0;
         end
      endcase
   end

   // Flags for the result
   logic [7:0] new_flags;
   ars_flags u_flags (
      .value_i          (op_res),
      .is_acc_i         (dst_is_acc),
      .op_i             (cmd.op),
      .carry_i          (single_c),
      .mv_limited_i     (cmd.mv_limited),
      .mv_size_growth_i (cmd.mv_size_growth),
      .flags_prev_i     (flags_prev),
      .flags_o          (new_flags)
   );

   // State decode and last move cycle
   wire         st_idle    = (state == ARS_ST_IDLE);
   wire         st_exec    = (state == ARS_ST_EXEC);
   wire         mv_last    = (mv_cnt == 2'b00);

   // Next result: old value and flags kept when refused
   wire  [35:0] next_value   = op_ok ? op_res : dst_val;
   wire  [7:0]  next_flags   = op_ok ? new_flags : flags_prev;
   wire         next_illegal = !op_ok;
   wire         next_valid   = (next_state == ARS_ST_DONE);

   // Sequencer: capture, execute, optional move cycles
   wire         take       = st_idle && cmd_valid_i;

   // Single shift with extra parallel-move cycles
   wire         op_single    = (cmd.op == ARS_OP_SINGLE);
   wire         is_single_mv = op_single && (cmd.mv_extra != 2'b00);
   always_comb begin
      next_state  = state;
      next_mv_cnt = mv_cnt;
      case (state)
         ARS_ST_IDLE: begin
            if (cmd_valid_i) begin
               next_state = ARS_ST_EXEC;
            end
         end
         ARS_ST_EXEC: begin
            if (is_single_mv) begin
               next_state  = ARS_ST_MOVE;
               next_mv_cnt = 2'(cmd.mv_extra - 2'd1);
            end else begin
               next_state = ARS_ST_DONE;
            end
         end
         ARS_ST_MOVE: begin
            if (mv_last) begin
               next_state = ARS_ST_DONE;
            end else begin
               next_mv_cnt = 2'(mv_cnt - 2'd1);
            end
         end
         ARS_ST_DONE: begin
            next_state = ARS_ST_IDLE;
         end
         default: begin
            next_state = ARS_ST_IDLE;
         end
      endcase
   end

   // State and move-cycle count
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state  <= ARS_ST_IDLE;
         mv_cnt <= 2'b00;
      end else begin
         state  <= next_state;
         mv_cnt <= next_mv_cnt;
      end
   end

   // Operands held for the whole operation
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cmd        <= '{op: ARS_OP_NONE, pair: ARS_PR_Y1_X0, dst: ARS_DST_ACC_A, default: '0};
         regs       <= '0;
         flags_prev <= `ARS_FLAGS_RST;
      end else if (take) begin
         cmd        <= cmd_i;
         regs       <= regs_i;
         flags_prev <= flags_i;
      end
   end

   // Result registered at the end of the execute cycle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         result <= '{dst: ARS_DST_ACC_A, value: `ARS_ACC_RST, flags: `ARS_FLAGS_RST};
      end else if (st_exec) begin
         result.dst   <= cmd.dst;
         result.value <= next_value;
         result.flags <= next_flags;
      end
   end

   // Refusal flag, shown with the result it belongs to
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         illegal <= 1'b0;
      end else if (st_exec) begin
         illegal <= next_illegal;
      end
   end

   // Done pulse as the last cycle closes
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         result_valid <= 1'b0;
      end else begin
         result_valid <= next_valid;
      end
   end

   // Handshake outputs; limit enable reaches no result
   assign cmd_ready_o    = st_idle;
   assign result_valid_o = result_valid;

   // Data outputs straight from flip-flops
   assign result_o       = result;
   assign illegal_o      = illegal;

endmodule // ars_unit

//--- test/ars_unit_assertions.sv
// Concurrent checks on the ports of the shift unit.
// Assumes a bind onto ars_unit; one clock, synchronous reset.
`timescale 1ns/10ps
module ars_unit_chk
   import ars_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        srst_i,
   // Command side
   input wire logic        cmd_valid_i,
   input wire ars_cmd_t    cmd_i,
   input wire ars_regs_t   regs_i,
   input wire logic [7:0]  flags_i,
   input wire logic        limit_enable_bit_i,
   // Result side
   input wire logic        cmd_ready_o,
   input wire logic        result_valid_o,
   input wire ars_result_t result_o,
   input wire logic        illegal_o
);
   // Taken command and a single shift with no move cycles
   wire take;
   wire sgl;
   assign take = cmd_valid_i && cmd_ready_o;
   assign sgl  = take && cmd_i.op == ARS_OP_SINGLE && cmd_i.mv_extra == 2'h0;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   chk_multi_timing: assert property (take && cmd_i.op inside {ARS_OP_ACCUM, ARS_OP_MULTI} |->
      !result_valid_o ##1 !result_valid_o ##1 result_valid_o) else $error("multi-bit result late or early");
   chk_single_timing: assert property (sgl |=> !result_valid_o ##1 result_valid_o)
      else $error("single shift result late or early");
   chk_valid_pulse: assert property (result_valid_o |=> !result_valid_o && cmd_ready_o)
      else $error("result valid not a single pulse");
   chk_ready_busy: assert property (take |=> !cmd_ready_o) else $error("ready while busy");
   chk_single_value: assert property (sgl && cmd_i.dst == ARS_DST_ACC_A |-> ##2
      result_o.value == {$past(regs_i.acc_a[35], 2), $past(regs_i.acc_a[35:1], 2)}) else $error("single shift value");
   chk_single_carry: assert property (sgl && cmd_i.dst == ARS_DST_ACC_A |-> ##2
      result_o.flags[0] == $past(regs_i.acc_a[0], 2) && !result_o.flags[1]
      && result_o.flags[6] == $past(cmd_i.mv_limited, 2)) else $error("single shift carry flags");
   chk_neg_flag: assert property (result_valid_o && !illegal_o && result_o.dst != ARS_DST_REG16 |->
      result_o.flags[3] == result_o.value[35]) else $error("negative flag");
   chk_zero_flag: assert property (result_valid_o && !illegal_o |->
      result_o.flags[2] == (result_o.value == 36'h0)) else $error("zero flag");
   chk_bad_pair: assert property (take && cmd_i.op inside {ARS_OP_ACCUM, ARS_OP_MULTI}
      && cmd_i.pair > ARS_PR_B1_Y1 |-> ##2 illegal_o) else $error("bad pair accepted");
   chk_low_clear: assert property (take && cmd_i.op == ARS_OP_MULTI && cmd_i.dst == ARS_DST_ACC_A
      && cmd_i.pair < ARS_PR_BAD6 |-> ##2 result_o.value[15:0] == 16'h0000
      && result_o.value[35:31] == {5{result_o.value[31]}}) else $error("lower word not cleared");

   // Main scenarios reached
   cover property (sgl);
   cover property (take && cmd_i.op == ARS_OP_ACCUM);
   cover property (result_valid_o && illegal_o);
endmodule // ars_unit_chk

bind ars_unit ars_unit_chk u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
   .cmd_i(cmd_i), .regs_i(regs_i), .flags_i(flags_i), .limit_enable_bit_i(limit_enable_bit_i),
   .cmd_ready_o(cmd_ready_o), .result_valid_o(result_valid_o), .result_o(result_o), .illegal_o(illegal_o));

//--- test/ars_dec_model.sv
// Decoder and register-file stand-in that issues commands to the unit.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/10ps
module ars_dec_model
   import ars_pkg::*;
(
   // Clock and handshake
   input  wire logic  ref_clk_i,
   input  wire logic  cmd_ready_i,
   // Command toward the unit
   output logic       cmd_valid_o,
   output ars_cmd_t   cmd_o,
   output ars_regs_t  regs_o,
   output logic [7:0] flags_o
);
   // Idle lines never show a stale command
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o       = '1;
      regs_o      = '1;
      flags_o     = '1;
   end

   // Hold the command until the taking edge, then scramble the lines
   task automatic send(input ars_cmd_t c, input ars_regs_t r, input logic [7:0] f);
      ars_cmd_t k;
      k                = c;
      k.mv_read_active = 1'b0;
      @(negedge ref_clk_i);
      cmd_valid_o      = 1'b1;
      cmd_o            = k;
      regs_o               = r;
      flags_o              = f;
      @(posedge ref_clk_i);
      while (cmd_ready_i !== 1'b1) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      cmd_valid_o = 1'b0;
      cmd_o       = ~c;
      regs_o      = ~r;
      flags_o     = ~f;
   endtask
endmodule // ars_dec_model

//--- test/tb_arith_right_shift_unit.sv
// Self-checking bench for the shift unit: corner cases, then random commands.
// Assumes the decoder model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_arith_right_shift_unit;
   import ars_pkg::*;
   logic        ref_clk_i;
   logic        srst_i;
   logic        cmd_valid_i;
   logic        lim_en;
   ars_cmd_t    cmd;
   ars_regs_t   regs;
   logic [7:0]  flg;
   logic        cmd_ready_o;
   logic        result_valid_o;
   ars_result_t result_o;
   logic        illegal_o;
   int          bad_count;
   int          total_checks;
   int          seed = 32'hbf4e_cae0;
   ars_regs_t   r;
   ars_cmd_t    c;

   ars_unit u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd),
      .regs_i(regs), .flags_i(flg), .limit_enable_bit_i(lim_en), .cmd_ready_o(cmd_ready_o),
      .result_valid_o(result_valid_o), .result_o(result_o), .illegal_o(illegal_o));
   ars_dec_model u_dec (.ref_clk_i(ref_clk_i), .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid_i),
      .cmd_o(cmd), .regs_o(regs), .flags_o(flg));

   // Clock
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // Value compare, flags compare under a mask
   task automatic cmp_word(string nm, logic [35:0] e, logic [35:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmp_flags(logic [7:0] m, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if ((g & m) !== (e & m)) begin
         bad_count++;
         $display("[FAIL] flags exp %h got %h", e & m, g & m);
      end
   endtask

   // Source pair as {first, second}
   function automatic logic [31:0] srcs(ars_pair_t p, ars_regs_t q);
      case (p)
         ARS_PR_Y1_X0: return {q.y1, q.x0};
         ARS_PR_Y0_X0: return {q.y0, q.x0};
         ARS_PR_Y1_Y0: return {q.y1, q.y0};
         ARS_PR_Y0_Y0: return {q.y0, q.y0};
         ARS_PR_A1_Y0: return {q.acc_a[31:16], q.y0};
         default:      return {q.acc_b[31:16], q.y1};
      endcase
   endfunction

   // Expected value, flags, flag mask and refusal
   task automatic expect_of(input ars_cmd_t k, input ars_regs_t q, input logic [7:0] f, output logic [35:0] v,
      output logic [7:0] ef, output logic [7:0] m, output logic il);
      logic [31:0] s;
      logic [35:0] d;
      logic [35:0] t;
      logic [15:0] sh;
      logic        acc;
      s   = srcs(k.pair, q);
      acc = (k.dst != ARS_DST_REG16);
      d   = (k.dst == ARS_DST_ACC_B) ? q.acc_b : (acc ? q.acc_a : {20'h0_0000, q.reg16});
      il  = (k.dst == ARS_DST_BAD) || (k.op != ARS_OP_SINGLE && k.pair > ARS_PR_B1_Y1)
            || (k.op == ARS_OP_ACCUM && !acc);
      t   = $signed({{4{s[31]}}, s[31:16], 16'h0000}) >>> s[3:0];
      sh  = $signed(s[31:16]) >>> s[3:0];
      ef  = f;
      m   = 8'hff;
      if (k.op == ARS_OP_SINGLE) v = acc ? {d[35], d[35:1]} : {20'h0_0000, d[15], d[15:1]};
      else if (k.op == ARS_OP_ACCUM) v = d + t;
      else v = acc ? {{4{sh[15]}}, sh, 16'h0000} : {20'h0_0000, sh};
      if (k.op == ARS_OP_SINGLE) begin
         ef[0] = d[0];
         ef[1] = 1'b0;
         ef[5] = !(&v[35:31] || ~|v[35:31]);
         ef[4] = acc ? ((v[31] == v[30]) && !ef[5]) : (v[15] == v[14]);
         ef[6] = k.mv_limited;
         ef[7] = k.mv_size_growth;
      end
      ef[2] = (v == 36'h0_0000_0000);
      ef[3] = acc ? v[35] : v[15];
      if (il) begin
         v  = d;
         ef = f;
      end
   endtask

   // Issue one command and check timing, refusal, value and flags
   task automatic run_op(ars_cmd_t k, ars_regs_t q, logic [7:0] f);
      logic [35:0] v;
      logic [7:0]  ef;
      logic [7:0]  m;
      logic        il;
      int          n;
      expect_of(k, q, f, v, ef, m, il);
      u_dec.send(k, q, f);
      n = 0;
      while (result_valid_o !== 1'b1 && n < 16) begin
         @(negedge ref_clk_i);
         n++;
      end
      cmp_word("latency", 36'((k.op == ARS_OP_SINGLE) ? 1 + k.mv_extra : 1), 36'(n));
      cmp_word("illegal", 36'(il), 36'(illegal_o));
      cmp_word("dst", 36'(k.dst), 36'(result_o.dst));
      if (!(il && k.dst == ARS_DST_BAD)) cmp_word("value", v, result_o.value);
      cmp_flags(m, ef, result_o.flags);
   endtask

   function automatic ars_cmd_t mk(ars_op_t o, ars_pair_t p, ars_dst_t d, logic [1:0] x);
      return {o, p, d, x, 1'b1, 1'b0, 1'b0};
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      bad_count++;
      complete_run();
   end

   // Main sequence
   initial begin
      bad_count    = 0;
      total_checks = 0;
      srst_i       = 1'b1;
      lim_en       = 1'b0;
      repeat (12) @(negedge ref_clk_i);
      srst_i  = 1'b0;
      r       = ars_regs_t'(136'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)}));
      r.acc_b = 36'ha_a864_a865;
      r.y1    = 16'hc003;
      r.x0    = 16'h0004;
      run_op(mk(ARS_OP_SINGLE, ARS_PR_Y1_X0, ARS_DST_ACC_B, 2'h0), r, 8'h00);
      run_op(mk(ARS_OP_ACCUM, ARS_PR_Y1_X0, ARS_DST_ACC_A, 2'h0), r, 8'hff);
      r.y1    = 16'haaaa;
      r.y0    = 16'h000f;
      lim_en  = 1'b1;
      run_op(mk(ARS_OP_MULTI, ARS_PR_Y1_X0, ARS_DST_ACC_A, 2'h0), r, 8'h00);
      run_op(mk(ARS_OP_MULTI, ARS_PR_A1_Y0, ARS_DST_REG16, 2'h0), r, 8'h00);
      run_op(mk(ARS_OP_MULTI, ARS_PR_BAD7, ARS_DST_ACC_A, 2'h0), r, 8'h5a);
      run_op(mk(ARS_OP_ACCUM, ARS_PR_Y0_Y0, ARS_DST_REG16, 2'h0), r, 8'ha5);
      r.acc_a = 36'h0_0000_0001;
      run_op(mk(ARS_OP_SINGLE, ARS_PR_Y1_X0, ARS_DST_ACC_A, 2'h3), r, 8'h00);
      for (int i = 0; i < 120; i++) begin
         c      = ars_cmd_t'(12'($random(seed)));
         c.op   = ars_op_t'(2'(i % 3));
         r      = ars_regs_t'(136'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)}));
         lim_en = 1'($random(seed));
         run_op(c, r, 8'($random(seed)));
      end
      complete_run();
   end
endmodule // tb_arith_right_shift_unit
